// ==== cfg_regs_pkg.sv ====
// Constants and types for the top configuration register bank
package cfg_regs_pkg;

  localparam int          ADDR_W          = 14;
  localparam int          DATA_W          = 16;
  localparam int          SLICES          = 4;
  localparam int          TEST_SEL_BIT    = 13;

  localparam logic [12:0] MASTER_OFFSET   = 13'h0000;
  localparam logic [12:0] RX_CFG_OFFSET   = 13'h0001;
  localparam logic [12:0] TX_CFG_OFFSET   = 13'h0002;

  // Master configuration field positions
  localparam int          QUAD_MODE_POS   = 0;
  localparam int          TU3_PD_POS      = 1;
  localparam int          JAT_RST_POS     = 2;
  localparam int          LAS_RST_POS     = 3;
  localparam int          QANA_RST_POS    = 4;
  localparam int          SANA_RST_POS    = 5;
  localparam int          SOFT_RST_POS    = 6;
  localparam int          SLICE_RST_LSB   = 7;
  localparam int          ICLR_MODE_POS   = 11;
  localparam int          HR_TOGGLE_POS   = 13;
  localparam int          XFER_BUSY_POS   = 15;

  // Receive and transmit field positions
  localparam int          SLAVE_LSB       = 0;
  localparam int          CONCAT_LSB      = 4;
  localparam int          SCR_DIS_POS     = 9;
  localparam int          SW_MODE_LSB     = 10;
  localparam int          PI_DIS_POS      = 12;

  // Writable masks and reset values
  localparam logic [15:0] MASTER_WMASK    = 16'h7FFC;
  localparam logic [15:0] MASTER_RESET    = 16'h0000;
  localparam logic [15:0] RX_CFG_WMASK    = 16'hFFFF;
  localparam logic [15:0] RX_CFG_RESET    = 16'h0400;
  localparam logic [15:0] TX_CFG_WMASK    = 16'hFFFF;
  localparam logic [15:0] TX_CFG_RESET    = 16'h9400;

  // Performance-monitor transfer time in cycles
  localparam int          PM_XFER_CYCLES  = 16;

  typedef enum logic [1:0] {
    SW_DYNAMIC = 2'b00,
    SW_BYPASS  = 2'b01,
    SW_MERGE   = 2'b10,
    SW_SPLIT   = 2'b11
  } switch_mode_type;

  typedef enum logic [1:0] {
    CC_NONE   = 2'b00,
    CC_MASTER = 2'b01,
    CC_SLAVE  = 2'b10
  } concat_mode_type;

endpackage

// ==== pm_transfer.sv ====
// Performance-monitor transfer timer driving the in-progress flag
`timescale 1ns/10ps
module pm_transfer
  import cfg_regs_pkg::*;
#(
  parameter int CYCLES = PM_XFER_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      load_o
);

  logic [15:0] count_r;

  // A fresh write restarts the transfer
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      count_r <= 16'h0000;
      busy_o  <= 1'b0;
      load_o  <= 1'b0;
    end else if (start_i) begin
      count_r <= 16'(CYCLES - 1);
      busy_o  <= 1'b1;
      load_o  <= 1'b1;
    end else begin
      load_o <= 1'b0;
      if (count_r != 16'h0000) begin
        count_r <= count_r - 16'h0001;
      end else begin
        busy_o <= 1'b0;
      end
    end
  end

  a_busy_ends: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    start_i ##1 (!start_i) [*8] |-> busy_o) else $error("transfer ended too early");

endmodule

// ==== cfg_regs.sv ====
// Top configuration register bank with soft resets and mode decoding
`timescale 1ns/10ps
module cfg_regs
  import cfg_regs_pkg::*;
#(
  parameter int XFER_CYCLES = PM_XFER_CYCLES
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  chip_select_bar_i,
  input  wire logic                  rd_bar_i,
  input  wire logic                  wr_bar_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [DATA_W-1:0]     wdata_i,
  input  wire logic                  quad_lane_mode_pin_i,
  input  wire logic                  tu3_powerdown_pin_i,
  output logic      [DATA_W-1:0]     rdata_o,
  output logic                       rdata_oe_o,
  output logic                       jitter_atten_reset_o,
  output logic                       line_side_regif_reset_o,
  output logic                       quad_analog_reset_o,
  output logic                       single_analog_reset_o,
  output logic                       digital_soft_reset_o,
  output logic      [SLICES-1:0]     slice_soft_reset_o,
  output logic                       interrupt_clear_mode_o,
  output logic                       highrate_clear_mode_o,
  output logic                       pm_transfer_load_o,
  output logic      [2*SLICES-1:0]   rx_concat_mode_o,
  output logic                       rx_descramble_disable_o,
  output logic      [1:0]            drop_switch_mode_o,
  output logic      [2*SLICES-1:0]   tx_concat_mode_o,
  output logic                       tx_scramble_disable_o,
  output logic                       add_ptr_interp_disable_o,
  output logic      [1:0]            add_switch_mode_o
);

  logic [15:0] master_r;
  logic [15:0] rx_cfg_r;
  logic [15:0] tx_cfg_r;
  logic        wr_prev_r;
  logic        wr_strobe;
  logic        rd_access;
  logic        normal_sel;
  logic        sel_master;
  logic        sel_rx;
  logic        sel_tx;
  logic        xfer_busy;
  logic        load_pulse;
  logic [15:0] read_mux;

  // Normal-mode access only while selected and test select low
  assign normal_sel = !chip_select_bar_i && !addr_i[TEST_SEL_BIT];
  assign sel_master = normal_sel && (addr_i[12:0] == MASTER_OFFSET);
  assign sel_rx     = normal_sel && (addr_i[12:0] == RX_CFG_OFFSET);
  assign sel_tx     = normal_sel && (addr_i[12:0] == TX_CFG_OFFSET);
  assign rd_access  = normal_sel && !rd_bar_i;

  // Write taken once, on the falling edge of the write strobe
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wr_prev_r <= 1'b0;
    end else begin
      wr_prev_r <= !wr_bar_i && !chip_select_bar_i;
    end
  end
  assign wr_strobe = !wr_bar_i && !chip_select_bar_i && !wr_prev_r;

  // Master register; read-only bits 0, 1 and 15 are masked out
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      master_r <= MASTER_RESET;
    end else if (wr_strobe && sel_master) begin
      master_r <= wdata_i & MASTER_WMASK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rx_cfg_r <= RX_CFG_RESET;
    end else if (wr_strobe && sel_rx) begin
      rx_cfg_r <= wdata_i & RX_CFG_WMASK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tx_cfg_r <= TX_CFG_RESET;
    end else if (wr_strobe && sel_tx) begin
      tx_cfg_r <= wdata_i & TX_CFG_WMASK;
    end
  end

  // Any master write restarts the counter snapshot
  pm_transfer #(
    .CYCLES (XFER_CYCLES)
  ) u_pm_transfer (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .start_i   (wr_strobe && sel_master),
    .busy_o    (xfer_busy),
    .load_o    (load_pulse)
  );

  // Read mux; status bits come live from pins and transfer timer
  always_comb begin
    read_mux = 16'h0000;
    if (sel_master) begin
      read_mux                = master_r;
      read_mux[QUAD_MODE_POS] = quad_lane_mode_pin_i;
      read_mux[TU3_PD_POS]    = tu3_powerdown_pin_i;
      read_mux[XFER_BUSY_POS] = xfer_busy;
    end else if (sel_rx) begin
      read_mux = rx_cfg_r;
    end else if (sel_tx) begin
      read_mux = tx_cfg_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rdata_o    <= 16'h0000;
      rdata_oe_o <= 1'b0;
    end else begin
      rdata_o    <= read_mux;
      rdata_oe_o <= rd_access;
    end
  end

  // Soft reset and clear-mode outputs, registered
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      jitter_atten_reset_o    <= 1'b0;
      line_side_regif_reset_o <= 1'b0;
      quad_analog_reset_o     <= 1'b0;
      single_analog_reset_o   <= 1'b0;
      digital_soft_reset_o    <= 1'b0;
      slice_soft_reset_o      <= 4'h0;
      interrupt_clear_mode_o  <= 1'b0;
      highrate_clear_mode_o   <= 1'b0;
      pm_transfer_load_o      <= 1'b0;
    end else begin
      jitter_atten_reset_o    <= master_r[JAT_RST_POS];
      line_side_regif_reset_o <= master_r[LAS_RST_POS];
      quad_analog_reset_o     <= master_r[QANA_RST_POS];
      single_analog_reset_o   <= master_r[SANA_RST_POS];
      // Attenuators and line interface take no part in this reset
      digital_soft_reset_o    <= master_r[SOFT_RST_POS];
      slice_soft_reset_o      <= master_r[SLICE_RST_LSB +: SLICES];
      interrupt_clear_mode_o  <= master_r[ICLR_MODE_POS];
      highrate_clear_mode_o   <= master_r[HR_TOGGLE_POS] ^ master_r[ICLR_MODE_POS];
      pm_transfer_load_o      <= load_pulse;
    end
  end

  // Per-slice concat decode: {slave, master} one-hot, 00 means none
  function automatic logic [1:0] concat_decode(input logic en, input logic sl);
    concat_decode = !en ? CC_NONE : (sl ? CC_SLAVE : CC_MASTER);
  endfunction

  genvar g;
  generate
    for (g = 0; g < SLICES; g++) begin : g_slice
      always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
          rx_concat_mode_o[2*g +: 2] <= CC_NONE;
          tx_concat_mode_o[2*g +: 2] <= CC_NONE;
        end else begin
          rx_concat_mode_o[2*g +: 2] <= concat_decode(rx_cfg_r[CONCAT_LSB+g], rx_cfg_r[SLAVE_LSB+g]);
          tx_concat_mode_o[2*g +: 2] <= concat_decode(tx_cfg_r[CONCAT_LSB+g], tx_cfg_r[SLAVE_LSB+g]);
        end
      end
    end
  endgenerate

  // Datapath mode controls
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rx_descramble_disable_o  <= 1'b0;
      drop_switch_mode_o       <= SW_BYPASS;
      tx_scramble_disable_o    <= 1'b0;
      add_ptr_interp_disable_o <= 1'b1;
      add_switch_mode_o        <= SW_BYPASS;
    end else begin
      rx_descramble_disable_o  <= rx_cfg_r[SCR_DIS_POS];
      drop_switch_mode_o       <= rx_cfg_r[SW_MODE_LSB +: 2];
      tx_scramble_disable_o    <= tx_cfg_r[SCR_DIS_POS];
      add_ptr_interp_disable_o <= tx_cfg_r[PI_DIS_POS];
      add_switch_mode_o        <= tx_cfg_r[SW_MODE_LSB +: 2];
    end
  end

  a_readonly_kept: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_strobe && sel_master) |=> (master_r[1:0] == 2'b00) && !master_r[15]) else $error("read-only bit stored");
  a_master_wr: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_strobe && sel_master) |=> master_r[14:2] == $past(wdata_i[14:2])) else $error("master write lost");
  a_busy_rise: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_strobe && sel_master) |=> xfer_busy) else $error("transfer flag not set");
  a_slice_reset: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (wr_strobe && sel_master) |-> ##2 slice_soft_reset_o == $past(wdata_i[10:7], 2)) else $error("slice reset wrong");
  a_hr_clear: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ##1 highrate_clear_mode_o == ($past(master_r[13]) ^ $past(master_r[11]))) else $error("high-rate clear mode wrong");
  a_rx_concat: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ##1 (!$past(rx_cfg_r[4]) |-> rx_concat_mode_o[1:0] == CC_NONE)) else $error("rx concat decode wrong");
  a_tx_slave: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ##1 (($past(tx_cfg_r[4]) && $past(tx_cfg_r[0])) |-> tx_concat_mode_o[1:0] == CC_SLAVE)) else $error("tx slave wrong");
  a_pin_mirror: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    sel_master |=> rdata_o[1:0] == $past({tu3_powerdown_pin_i, quad_lane_mode_pin_i})) else $error("mode pins not mirrored");
  a_reset_vals: assert property (@(posedge sys_clk_i)
    !nrst_i |=> (tx_cfg_r == TX_CFG_RESET) && (rx_cfg_r == RX_CFG_RESET) && (master_r == 16'h0000)) else $error("reset value wrong");

endmodule

// ==== host_bus_model.sv ====
// Host processor model for the parallel register bus
`timescale 1ns/10ps
module host_bus_model
  import cfg_regs_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  input  wire logic              rdata_oe_i,
  output logic                   chip_select_bar_o,
  output logic                   rd_bar_o,
  output logic                   wr_bar_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o
);
  initial begin
    chip_select_bar_o = 1'b1;
    rd_bar_o          = 1'b1;
    wr_bar_o          = 1'b1;
    addr_o            = '0;
    wdata_o           = '0;
  end
  // Released address and data lines flip so a stale value never passes for a live one
  task automatic release_bus();
    chip_select_bar_o <= 1'b1;
    rd_bar_o          <= 1'b1;
    wr_bar_o          <= 1'b1;
    addr_o            <= ~addr_o;
    wdata_o           <= ~wdata_o;
  endtask
  // Caller keeps unused bits zero and reserved bits at default
  task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    chip_select_bar_o <= 1'b0;
    wr_bar_o          <= 1'b0;
    addr_o            <= a;
    wdata_o           <= d;
    @(posedge sys_clk_i);
    release_bus();
    // Write strobe must stay high a cycle before the next write
    @(posedge sys_clk_i);
  endtask
  task automatic read_word(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic oe);
    @(posedge sys_clk_i);
    chip_select_bar_o <= 1'b0;
    rd_bar_o          <= 1'b0;
    addr_o            <= a;
    @(posedge sys_clk_i);
    #1;
    d  = rdata_i;
    oe = rdata_oe_i;
    @(posedge sys_clk_i);
    release_bus();
  endtask
endmodule

// ==== top_config_reset_regs_tb.sv ====
// Self-checking bench for the top configuration register bank
`timescale 1ns/10ps
module top_config_reset_regs_tb;
  import cfg_regs_pkg::*;
  localparam int XFER = 8;
  logic              sys_clk_i, nrst_i, cs_b, rd_b, wr_b, qpin, tpin, oe, rdoe;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, m, r, t, d;
  logic              jr, lr, qr, sr, dr, icm, hcm, load, rds, txs, api;
  logic [3:0]        slr;
  logic [7:0]        rxc, txc;
  logic [1:0]        dsw, asw;
  int                seed, miscompares, checked, pulses, writes;
  host_bus_model host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .rdata_oe_i(rdoe), .chip_select_bar_o(cs_b),
    .rd_bar_o(rd_b), .wr_bar_o(wr_b), .addr_o(addr), .wdata_o(wdata));
  cfg_regs #(.XFER_CYCLES(XFER)) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .chip_select_bar_i(cs_b),
    .rd_bar_i(rd_b), .wr_bar_i(wr_b), .addr_i(addr), .wdata_i(wdata), .quad_lane_mode_pin_i(qpin),
    .tu3_powerdown_pin_i(tpin), .rdata_o(rdata), .rdata_oe_o(rdoe), .jitter_atten_reset_o(jr),
    .line_side_regif_reset_o(lr), .quad_analog_reset_o(qr), .single_analog_reset_o(sr),
    .digital_soft_reset_o(dr), .slice_soft_reset_o(slr), .interrupt_clear_mode_o(icm),
    .highrate_clear_mode_o(hcm), .pm_transfer_load_o(load), .rx_concat_mode_o(rxc),
    .rx_descramble_disable_o(rds), .drop_switch_mode_o(dsw), .tx_concat_mode_o(txc),
    .tx_scramble_disable_o(txs), .add_ptr_interp_disable_o(api), .add_switch_mode_o(asw));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) if (load === 1'b1) pulses++;
  function automatic logic [7:0] concat(input logic [15:0] v);
    for (int i = 0; i < SLICES; i++) concat[2*i+:2] = v[CONCAT_LSB+i] ? (v[SLAVE_LSB+i] ? 2'b10 : 2'b01) : 2'b00;
  endfunction
  task automatic end_of_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_rd(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED read t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_ctl(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED control t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_write(input logic [13:0] a, input logic [15:0] v);
    host.write_word(a, v);
    if (a[13] == 1'b0 && a[12:0] == MASTER_OFFSET) m = v & 16'h2FFC;
    if (a[13] == 1'b0 && a[12:0] == MASTER_OFFSET) writes++;
    if (a[13] == 1'b0 && a[12:0] == RX_CFG_OFFSET) r = v;
    if (a[13] == 1'b0 && a[12:0] == TX_CFG_OFFSET) t = v;
  endtask
  task automatic verify_all();
    host.read_word(14'h0000, d, oe);
    check_rd(d & 16'h2FFF, m | {14'h0, tpin, qpin});
    host.read_word(14'h0001, d, oe);
    check_rd(d, r);
    check_rd({15'h0, oe}, 16'h0001);
    host.read_word(14'h0002, d, oe);
    check_rd(d, t);
    check_ctl({5'h0, jr, lr, qr, sr, dr, slr, icm, hcm},
      {5'h0, m[2], m[3], m[4], m[5], m[6], m[10:7], m[11], m[13] ^ m[11]});
    check_ctl({rxc, 5'h0, rds, dsw}, {concat(r), 5'h0, r[9], r[11:10]});
    check_ctl({txc, 4'h0, txs, api, asw}, {concat(t), 4'h0, t[9], t[12], t[11:10]});
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    end_of_test();
  end
  initial begin
    seed = 27;
    nrst_i = 1'b0;
    qpin = 1'b0;
    tpin = 1'b0;
    m = 16'h0000;
    r = 16'h0400;
    t = 16'h9400;
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    verify_all();
    host.read_word(14'h0003, d, oe);
    check_rd(d, 16'h0000);
    // Test-select reads must not drive the data bus
    host.read_word(14'h2000, d, oe);
    check_rd(d, 16'h0000);
    check_rd({15'h0, oe}, 16'h0000);
    // Test-select writes must leave normal registers alone
    do_write(14'h2001, 16'h0EFF);
    verify_all();
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk_i);
      qpin <= $random(seed);
      tpin <= $random(seed);
      d = $random(seed);
      case ({$random(seed)} % 5)
        0: do_write(14'h0000, d & 16'hAFFF);
        1: do_write(14'h0001, d & 16'h0EFF);
        2: do_write(14'h0002, (d & 16'h1EFF) | 16'h8000);
        3: do_write(14'h0003, d & 16'h0FFF);
        default: do_write(14'h2002, d);
      endcase
      verify_all();
    end
    // Transfer flag rises on a master write and clears after the count
    do_write(14'h0000, 16'h2804);
    host.read_word(14'h0000, d, oe);
    check_rd(d & 16'h8000, 16'h8000);
    repeat (XFER + 4) @(posedge sys_clk_i);
    host.read_word(14'h0000, d, oe);
    check_rd(d & 16'h8000, 16'h0000);
    check_ctl(pulses[15:0], writes[15:0]);
    end_of_test();
  end
endmodule
